// >>> pkg/amb_pkg.sv
// constants and carriers for the add-on mailbox status and interrupt block
package amb_pkg;
    // register byte addresses on the add-on bus
    localparam logic [7:0] MBX_STATUS_OFS = 8'h34;
    localparam logic [7:0] INT_CTRL_OFS   = 8'h38;
    localparam logic [31:0] MBX_STATUS_RST = 32'h0000_0000;
    localparam logic [31:0] INT_CTRL_RST   = 32'h0000_0c0c;
    // status word field positions
    localparam int OUT_FULL_LSB = 28;
    localparam int IN_FULL_LSB  = 12;
    // interrupt register field positions
    localparam int INT_ASSERT_BIT = 23;
    localparam int BIST_BIT       = 20;
    localparam int OUT_INT_BIT    = 17;
    localparam int IN_INT_BIT     = 16;
    localparam int OUT_EN_BIT     = 12;
    localparam int OUT_SEL_LSB    = 8;
    localparam int IN_EN_BIT      = 4;
    localparam int IN_SEL_LSB     = 0;
    localparam logic [31:0] INT_FIXED_ONES = 32'h0000_0c0c;
    // byte lanes that hold writable or clearable fields
    localparam int LANE_FLAGS = 2;
    localparam int LANE_OUT   = 1;
    localparam int LANE_IN    = 0;

    // add-on register access, one cycle per strobe
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } amb_req_t;

    // per-byte mailbox events from both sides, plus the PCI self-test write
    typedef struct packed {
        logic [3:0] addon_out_wr;
        logic [3:0] addon_in_rd;
        logic [3:0] pci_in_wr;
        logic [3:0] pci_out_rd;
        logic       pci_bist_wr;
    } amb_evt_t;
endpackage

// >>> rtl/amb_status_irq.sv
// add-on mailbox full/empty status and add-on interrupt control
// Notes on behaviour
// - add-on write sets outgoing full bit 31:28; PCI read of byte clears it
// - PCI write sets incoming full bit 15:12; add-on read of byte clears it
// - outgoing bits map bit 31 to byte 3 down to bit 28 byte 0
// - incoming bits map bit 15 to byte 3 down to bit 12 byte 0
// - incoming carries PCI to add-on, outgoing add-on to PCI
// - the same status word is shown to the PCI side
// - add-on interrupt drives whenever enabled conditions are flagged
// - bit 23 reads as OR of flags 20, 17 and 16
// - PCI self-test write sets bit 20 until add-on writes one
// - PCI read of outgoing mailbox sets flag bit 17
// - PCI write of incoming mailbox sets flag bit 16
// - flags 17 and 16 clear on write one, keep on zero
// - bit 12 enables outgoing mailbox read interrupt
// - bits 9:8 pick the outgoing byte, 00 byte 0 to 11 byte 3
// - bit 4 enables incoming mailbox write interrupt
// - bits 1:0 pick the incoming byte, 00 byte 0 to 11 byte 3
`timescale 1ns/1ns
`default_nettype none
module amb_status_irq
    import amb_pkg::*;
#(
    parameter int MBX_BYTES = 4
)
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire amb_req_t    req,
    input  wire amb_evt_t    evt,
    output logic [31:0]      rdata,
    output logic [31:0]      host_side_mailbox_status,
    output logic             addon_irq
);
    // ****************************************
    // elaboration check
    // ****************************************
    if (MBX_BYTES != 4)
    begin : g_bad
        $error("mailbox width must be four bytes");
    end

    // ****************************************
    // state
    // ****************************************
    logic [3:0]  out_full_r;
    logic [3:0]  out_full_nxt;
    logic [3:0]  in_full_r;
    logic [3:0]  in_full_nxt;
    logic        bist_r;
    logic        bist_nxt;
    logic        out_int_r;
    logic        out_int_nxt;
    logic        in_int_r;
    logic        in_int_nxt;
    logic        out_en_r;
    logic        out_en_nxt;
    logic [1:0]  out_sel_r;
    logic [1:0]  out_sel_nxt;
    logic        in_en_r;
    logic        in_en_nxt;
    logic [1:0]  in_sel_r;
    logic [1:0]  in_sel_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    logic        int_wr;
    logic        out_set;
    logic        in_set;
    logic        out_clr;
    logic        in_clr;
    logic        bist_clr;
    logic [31:0] status_word;
    logic [31:0] int_word;
    logic [3:0]  out_drain;
    logic [3:0]  in_drain;

    // ****************************************
    // register words
    // ****************************************
    always_comb
    begin
        status_word = MBX_STATUS_RST;
        status_word[OUT_FULL_LSB +: 4] = out_full_r;
        status_word[IN_FULL_LSB +: 4]  = in_full_r;
        int_word = INT_FIXED_ONES;
        int_word[INT_ASSERT_BIT] = bist_r | out_int_r | in_int_r;
        int_word[BIST_BIT]       = bist_r;
        int_word[OUT_INT_BIT]    = out_int_r;
        int_word[IN_INT_BIT]     = in_int_r;
        int_word[OUT_EN_BIT]     = out_en_r;
        int_word[OUT_SEL_LSB +: 2] = out_sel_r;
        int_word[IN_EN_BIT]      = in_en_r;
        int_word[IN_SEL_LSB +: 2]  = in_sel_r;
    end

    // one word seen from both buses, so no skew between them
    assign host_side_mailbox_status = status_word;
    assign addon_irq = int_word[INT_ASSERT_BIT];
    assign rdata = rdata_r;

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        int_wr = req.wr && (req.addr == INT_CTRL_OFS);
        // a write in the same cycle as a drain keeps the byte full
        out_full_nxt = (out_full_r & ~evt.pci_out_rd)
                     | evt.addon_out_wr;
        in_full_nxt  = (in_full_r & ~evt.addon_in_rd)
                     | evt.pci_in_wr;
        out_set = out_en_r && evt.pci_out_rd[out_sel_r];
        in_set  = in_en_r && evt.pci_in_wr[in_sel_r];
        out_clr = int_wr && req.be[LANE_FLAGS]
               && req.wdata[OUT_INT_BIT];
        in_clr  = int_wr && req.be[LANE_FLAGS]
               && req.wdata[IN_INT_BIT];
        bist_clr = int_wr && req.be[LANE_FLAGS]
                && req.wdata[BIST_BIT];
        // set wins over clear so no event is lost
        out_int_nxt = out_set | (out_int_r & ~out_clr);
        in_int_nxt  = in_set | (in_int_r & ~in_clr);
        bist_nxt    = evt.pci_bist_wr | (bist_r & ~bist_clr);
        out_en_nxt  = out_en_r;
        out_sel_nxt = out_sel_r;
        in_en_nxt   = in_en_r;
        in_sel_nxt  = in_sel_r;
        if (int_wr && req.be[LANE_OUT])
        begin
            out_en_nxt  = req.wdata[OUT_EN_BIT];
            out_sel_nxt = req.wdata[OUT_SEL_LSB +: 2];
        end
        if (int_wr && req.be[LANE_IN])
        begin
            in_en_nxt  = req.wdata[IN_EN_BIT];
            in_sel_nxt = req.wdata[IN_SEL_LSB +: 2];
        end
        rdata_nxt = rdata_r;
        if (req.rd)
        begin
            unique case (req.addr)
                MBX_STATUS_OFS: rdata_nxt = status_word;
                INT_CTRL_OFS:   rdata_nxt = int_word;
                default:        rdata_nxt = MBX_STATUS_RST;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            out_full_r <= MBX_STATUS_RST[OUT_FULL_LSB +: 4];
            in_full_r  <= MBX_STATUS_RST[IN_FULL_LSB +: 4];
            bist_r     <= INT_CTRL_RST[BIST_BIT];
            out_int_r  <= INT_CTRL_RST[OUT_INT_BIT];
            in_int_r   <= INT_CTRL_RST[IN_INT_BIT];
            out_en_r   <= INT_CTRL_RST[OUT_EN_BIT];
            out_sel_r  <= INT_CTRL_RST[OUT_SEL_LSB +: 2];
            in_en_r    <= INT_CTRL_RST[IN_EN_BIT];
            in_sel_r   <= INT_CTRL_RST[IN_SEL_LSB +: 2];
            rdata_r    <= MBX_STATUS_RST;
        end
        else
        begin
            out_full_r <= out_full_nxt;
            in_full_r  <= in_full_nxt;
            bist_r     <= bist_nxt;
            out_int_r  <= out_int_nxt;
            in_int_r   <= in_int_nxt;
            out_en_r   <= out_en_nxt;
            out_sel_r  <= out_sel_nxt;
            in_en_r    <= in_en_nxt;
            in_sel_r   <= in_sel_nxt;
            rdata_r    <= rdata_nxt;
        end
    end

    // self-test completion codes go back through the reset control
    // register, which lives outside this block

    // ****************************************
    // checks
    // ****************************************
    assign out_drain = evt.pci_out_rd & ~evt.addon_out_wr;
    assign in_drain  = evt.addon_in_rd & ~evt.pci_in_wr;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_rd_int;
        req.rd && req.addr == INT_CTRL_OFS;
    endsequence

    // a raised flag with no write one must stay up
    sequence s_out_keep;
        out_int_r && !out_clr;
    endsequence

    sequence s_in_keep;
        in_int_r && !in_clr;
    endsequence

    // self-test raised, then two cycles with no clear
    sequence s_bist_raised;
        evt.pci_bist_wr;
    endsequence

    sequence s_bist_left;
        !bist_clr [*2];
    endsequence

    sequence s_wr_out_lane;
        int_wr && req.be[LANE_OUT];
    endsequence

    sequence s_wr_in_lane;
        int_wr && req.be[LANE_IN];
    endsequence

    // first cycle out of reset, however long the reset lasted
    sequence s_reset_left;
        $fell(rst);
    endsequence

    a_out_fill: assert property (
        |evt.addon_out_wr |=> (host_side_mailbox_status[31:28]
            & $past(evt.addon_out_wr)) == $past(evt.addon_out_wr))
        else $error("outgoing full bit not set by add-on write");
    a_out_drain: assert property (
        |out_drain |=> (host_side_mailbox_status[31:28]
            & $past(out_drain)) == 4'h0)
        else $error("outgoing full bit not cleared by PCI read");
    a_in_fill: assert property (
        |evt.pci_in_wr |=> (host_side_mailbox_status[15:12]
            & $past(evt.pci_in_wr)) == $past(evt.pci_in_wr))
        else $error("incoming full bit not set by PCI write");
    a_in_drain: assert property (
        |in_drain |=> (host_side_mailbox_status[15:12]
            & $past(in_drain)) == 4'h0)
        else $error("incoming full bit not cleared by add-on read");
    a_status_same: assert property (
        (req.rd && req.addr == MBX_STATUS_OFS)
            |=> rdata == $past(host_side_mailbox_status))
        else $error("add-on status read differs from host view");
    a_irq_or: assert property (
        addon_irq == (bist_r || out_int_r || in_int_r))
        else $error("interrupt output not the OR of flags");
    a_bist_sticky: assert property (
        (s_bist_raised ##1 s_bist_left) |=> addon_irq)
        else $error("self-test flag lost before clear");
    a_out_flag_set: assert property (
        (out_en_r && evt.pci_out_rd[out_sel_r]) |=> out_int_r ##0 addon_irq)
        else $error("outgoing flag not set");
    a_in_flag_set: assert property (
        (in_en_r && evt.pci_in_wr[in_sel_r]) |=> in_int_r)
        else $error("incoming flag not set");
    a_flag_w1c: assert property (
        (out_clr && !out_set) |=> !out_int_r)
        else $error("outgoing flag not cleared by write one");
    a_flag_quiet: assert property (
        (!out_int_r && !(out_en_r && evt.pci_out_rd[out_sel_r]))
            |=> !out_int_r)
        else $error("outgoing flag set without selected byte");
    a_rsvd_read: assert property (
        s_rd_int |=> rdata[31:24] == 8'h00 && rdata[11:10] == 2'b11
            && rdata[3:2] == 2'b11 && rdata[7:5] == 3'b000)
        else $error("reserved or hardwired bits wrong");
    a_rsvd_mid: assert property (
        s_rd_int |=> rdata[22:21] == 2'b00 && rdata[19:18] == 2'b00
            && rdata[15:13] == 3'b000)
        else $error("reserved middle bits not zero");
    a_irq_read: assert property (
        s_rd_int |=> rdata[INT_ASSERT_BIT] == (rdata[BIST_BIT]
            || rdata[OUT_INT_BIT] || rdata[IN_INT_BIT]))
        else $error("interrupt asserted bit not the OR of flags");
    a_in_w1c: assert property (
        (in_clr && !in_set) |=> !in_int_r)
        else $error("incoming flag not cleared by write one");
    a_out_keep: assert property (
        s_out_keep |=> out_int_r)
        else $error("outgoing flag lost without write one");
    a_in_keep: assert property (
        s_in_keep |=> in_int_r)
        else $error("incoming flag lost without write one");
    a_bist_w1c: assert property (
        (bist_clr && !evt.pci_bist_wr) |=> !bist_r)
        else $error("self-test flag not cleared by write one");
    a_in_quiet: assert property (
        (!in_int_r && !(in_en_r && evt.pci_in_wr[in_sel_r]))
            |=> !in_int_r)
        else $error("incoming flag set without selected byte");
    a_out_ctrl: assert property (
        s_wr_out_lane |=> out_en_r == $past(req.wdata[OUT_EN_BIT])
            && out_sel_r == $past(req.wdata[OUT_SEL_LSB +: 2]))
        else $error("outgoing enable or select not written");
    a_in_ctrl: assert property (
        s_wr_in_lane |=> in_en_r == $past(req.wdata[IN_EN_BIT])
            && in_sel_r == $past(req.wdata[IN_SEL_LSB +: 2]))
        else $error("incoming enable or select not written");
    // status moves only on mailbox events, never on a bus write
    a_status_ro: assert property (
        (evt == '0) |=> $stable(host_side_mailbox_status))
        else $error("status word moved without a mailbox event");
    // words checked once the synchronous reset lets go
    a_reset_words: assert property (
        s_reset_left |-> int_word == INT_CTRL_RST
            && host_side_mailbox_status == MBX_STATUS_RST && !addon_irq)
        else $error("register words not at their reset values");
endmodule
`default_nettype wire

// >>> verif/amb_addon_model.sv
// add-on user logic model: register accesses on the add-on bus
`timescale 1ns/1ns
`default_nettype none
module amb_addon_model
    import amb_pkg::*;
(
    input  wire logic        clk,
    output var  amb_req_t    req,
    input  wire logic [31:0] rdata
);
    initial req = '0;

    // one strobe cycle, then wait for the registered answer
    // a read when w is low, a write when w is high, never both in one strobe
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [3:0] b, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        req <= '{wr: w, rd: !w, addr: a, be: b, wdata: d};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
        q = rdata;
    endtask
endmodule
`default_nettype wire

// >>> verif/amb_status_irq_test.sv
// self-checking bench for the add-on mailbox status and interrupt block
`timescale 1ns/1ns
`default_nettype none
module amb_status_irq_test
    import amb_pkg::*;
;
    typedef struct packed {
        logic [15:0] ctl;
        logic [16:0] ev;
        logic [31:0] st;
        logic [31:0] iw;
    } amb_row_t;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    amb_evt_t    evt = '0;
    amb_req_t    req;
    logic [31:0] rdata;
    logic [31:0] hs;
    logic        irq;
    logic [31:0] q;
    int          err_count = 0;
    int          tests_run = 0;
    // reset control register sits outside this block
    localparam logic [7:0] RST_CTRL_OFS = 8'h3c;
    // ctl, events, expected status, expected interrupt word
    amb_row_t    rows [14] = '{
        '{16'h0010, 17'h0_0020, 32'h0000_1000, 32'h0081_0c1c},
        '{16'h0011, 17'h0_0040, 32'h0000_2000, 32'h0081_0c1d},
        '{16'h0012, 17'h0_0080, 32'h0000_4000, 32'h0081_0c1e},
        '{16'h0013, 17'h0_0100, 32'h0000_8000, 32'h0081_0c1f},
        '{16'h0013, 17'h0_00e0, 32'h0000_7000, 32'h0000_0c1f},
        '{16'h0001, 17'h0_0040, 32'h0000_2000, 32'h0000_0c0d},
        '{16'h1000, 17'h0_0002, 32'h0000_0000, 32'h0082_1c0c},
        '{16'h1300, 17'h0_0010, 32'h0000_0000, 32'h0082_1f0c},
        '{16'h1100, 17'h1_e000, 32'hf000_0000, 32'h0000_1d0c},
        '{16'h1200, 17'h0_0004, 32'h0000_0000, 32'h0000_1e0c},
        '{16'h1100, 17'h0_0004, 32'h0000_0000, 32'h0082_1d0c},
        '{16'h1200, 17'h0_0008, 32'h0000_0000, 32'h0082_1e0c},
        '{16'h0000, 17'h0_2222, 32'h1000_1000, 32'h0000_0c0c},
        '{16'h0000, 17'h0_0001, 32'h0000_0000, 32'h0090_0c0c}};

    initial forever #50 clk = ~clk;

    amb_addon_model i_host (.clk(clk), .req(req), .rdata(rdata));

    amb_status_irq #(.MBX_BYTES(4)) i_dut (
        .clk(clk), .rst(rst), .req(req), .evt(evt), .rdata(rdata),
        .host_side_mailbox_status(hs), .addon_irq(irq));

    task automatic chk(input string n, input logic [31:0] s, e);
        tests_run++;
        if (s !== e)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    // events are pulses; effect is settled two edges later
    task automatic pulse(input logic [16:0] e);
        @(posedge clk) evt <= e;
        @(posedge clk) evt <= '0;
        @(posedge clk);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // generous bound: the sequence needs well under 1500 cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        err_count++;
        final_report();
    end

    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        i_host.acc(0, INT_CTRL_OFS, 4'hf, 0, q);
        chk("int reset", q, INT_CTRL_RST);
        i_host.acc(0, MBX_STATUS_OFS, 4'hf, 0, q);
        chk("status reset", q, MBX_STATUS_RST);
        chk("irq reset", {31'h0, irq}, 32'h0000_0000);
        foreach (rows[i])
        begin
            i_host.acc(1, INT_CTRL_OFS, 4'h3, {16'h0, rows[i].ctl}, q);
            pulse(rows[i].ev);
            chk("host status", hs, rows[i].st);
            i_host.acc(0, MBX_STATUS_OFS, 4'hf, 0, q);
            chk("status reg", q, rows[i].st);
            i_host.acc(0, INT_CTRL_OFS, 4'hf, 0, q);
            chk("int word", q, rows[i].iw);
            chk("irq", {31'h0, irq}, {31'h0, rows[i].iw[23]});
            // disable first so draining cannot raise a new flag
            i_host.acc(1, INT_CTRL_OFS, 4'h3, 0, q);
            pulse(17'h0_1e1e);
            i_host.acc(1, INT_CTRL_OFS, 4'h4, 32'h00ff_0000, q);
        end
        i_host.acc(1, INT_CTRL_OFS, 4'h3, 32'h0000_0010, q);
        pulse(17'h0_0020);
        i_host.acc(1, INT_CTRL_OFS, 4'h4, 32'h0000_0000, q);
        i_host.acc(0, INT_CTRL_OFS, 4'hf, 0, q);
        chk("w1c zero", q, 32'h0081_0c1c);
        i_host.acc(1, INT_CTRL_OFS, 4'h4, 32'h0001_0000, q);
        i_host.acc(0, INT_CTRL_OFS, 4'hf, 0, q);
        chk("w1c one", q, 32'h0000_0c1c);
        chk("irq off", {31'h0, irq}, 32'h0000_0000);
        pulse(17'h0_0200);
        chk("in drained", hs, 32'h0000_0000);
        pulse(17'h0_0001);
        i_host.acc(1, INT_CTRL_OFS, 4'h4, 32'h0010_0000, q);
        i_host.acc(0, INT_CTRL_OFS, 4'hf, 0, q);
        chk("bist clear", q, 32'h0000_0c1c);
        i_host.acc(1, INT_CTRL_OFS, 4'hf, 32'hffff_ffff, q);
        i_host.acc(0, INT_CTRL_OFS, 4'hf, 0, q);
        chk("fixed bits", q, 32'h0000_1f1f);
        i_host.acc(1, MBX_STATUS_OFS, 4'hf, 32'hffff_ffff, q);
        i_host.acc(0, MBX_STATUS_OFS, 4'hf, 0, q);
        chk("status ro", q, 32'h0000_0000);
        // completion codes go to the reset control register, not held here
        i_host.acc(1, RST_CTRL_OFS, 4'hf, 32'h0000_00a5, q);
        i_host.acc(0, RST_CTRL_OFS, 4'hf, 0, q);
        chk("unmapped", q, 32'h0000_0000);
        i_host.acc(0, INT_CTRL_OFS, 4'hf, 0, q);
        chk("codes ignored", q, 32'h0000_1f1f);
        pulse(17'h0_0100);
        chk("irq pre rst", {31'h0, irq}, 32'h0000_0001);
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        i_host.acc(0, INT_CTRL_OFS, 4'hf, 0, q);
        chk("int rerst", q, INT_CTRL_RST);
        chk("status rerst", hs, MBX_STATUS_RST);
        final_report();
    end
endmodule
`default_nettype wire
